// ===== sdm_pkg.sv
// package for the scope display memory control block
package sdm_pkg;
	localparam int ADDR_W      = 15;
	localparam int CNT_W       = 12;
	localparam int DISP_CNT_W  = 14;
	localparam int DATA_W      = 8;
	localparam int XDAC_W      = 10;
	localparam int XDAC_LSB    = 2;
	localparam int HOST_CTL_W  = 7;
	localparam int STEP_SEL_W  = 3;
	localparam int STATIC_W    = 2;
	// host control word bit positions
	localparam int CB_CPU_EN   = 0;
	localparam int CB_DSP_EN   = 1;
	localparam int CB_COPY     = 2;
	localparam int CB_DUAL     = 3;
	localparam int CB_STEP0    = 4;
	// register memory lies above the display memory in the 32K space
	localparam logic [ADDR_W-1:0] REG_BASE = 15'h2000;
	localparam logic [DATA_W-1:0] RESET_PATTERN = 8'h80;
	// counter select codes
	localparam logic [1:0] SEL_XFER = 2'b00;
	localparam logic [1:0] SEL_DISP = 2'b01;
	localparam logic [1:0] SEL_XDEF = 2'b10;
	typedef enum logic [2:0] {
		SDM_IDLE  = 3'b000,
		SDM_XFER  = 3'b001,
		SDM_XWAIT = 3'b010,
		SDM_FETCH = 3'b011,
		SDM_SHOW  = 3'b100,
		SDM_CRD   = 3'b101,
		SDM_CWR   = 3'b110
	} sdm_state_t;
endpackage : sdm_pkg

// ===== sdm_display_ctrl.sv
// display memory addressing, sample handshake and deflection output control
`timescale 1ns/1ps
`default_nettype none
module sdm_display_ctrl #(
	parameter int XFER_LEN = 8192
) (
	// clock and reset
	input  wire logic                       ref_clk,
	input  wire logic                       rstn,
	// acquisition handshake
	input  wire logic                       sample_ready_strobe,
	input  wire logic [sdm_pkg::DATA_W-1:0] sample_data,
	output logic                            latch_read_enable_n,
	output logic                            acq_halt,
	// host control port
	input  wire logic [sdm_pkg::DATA_W-1:0] host_data_bus,
	input  wire logic                       control_latch_strobe,
	input  wire logic [sdm_pkg::STATIC_W-1:0] host_static_bits,
	input  wire logic [sdm_pkg::ADDR_W-1:0] host_addr,
	input  wire logic                       host_wr,
	input  wire logic                       host_rd,
	output logic [sdm_pkg::DATA_W-1:0]      host_rdata,
	input  wire logic                       disp_preset_load,
	// status inputs
	input  wire logic                       transfer_terminal_count,
	input  wire logic                       lock_in,
	// display mode inputs
	input  wire logic                       memory_mode_n,
	input  wire logic                       trace_mode_signal,
	input  wire logic                       signal_intensity_n,
	input  wire logic                       text_intensity,
	input  wire logic                       text_clock,
	input  wire logic                       signal_xy_clock,
	input  wire logic [sdm_pkg::DATA_W-1:0] text_y,
	input  wire logic [sdm_pkg::XDAC_W-1:0] text_x,
	// memory port
	output logic [sdm_pkg::ADDR_W-1:0]      display_address,
	output logic [sdm_pkg::DATA_W-1:0]      mem_wdata,
	input  wire logic [sdm_pkg::DATA_W-1:0] display_data_out,
	output logic                            ram_select_n,
	output logic                            ram_write_enable_n,
	output logic                            cpu_ram_enable_n,
	output logic                            latch_to_ram_n,
	output logic                            transfer_count_clock,
	output logic                            high_bit_set_n,
	output logic                            high_bit_reset_n,
	output logic                            high_bit_clock,
	output logic                            copy_latch_clock,
	output logic                            copy_latch_enable_n,
	output logic [1:0]                      counter_select,
	// deflection outputs
	output logic [sdm_pkg::DATA_W-1:0]      y_dac_code,
	output logic [sdm_pkg::XDAC_W-1:0]      x_dac_code,
	output logic                            spot_intensity_n,
	output logic                            xy_source_switch
);
	localparam int CW = sdm_pkg::CNT_W;
	localparam int DW = sdm_pkg::DATA_W;
	localparam int AW = sdm_pkg::ADDR_W;

	sdm_pkg::sdm_state_t state_reg;

	logic [sdm_pkg::HOST_CTL_W-1:0] ctl_first_reg;
	logic [sdm_pkg::HOST_CTL_W-1:0] ctl_sync_reg;
	logic                           strobe_meta_reg;
	logic                           strobe_sync_reg;
	// counter 0 transfer, 1 display fetch, 2 X deflection or copy target
	logic [CW-1:0]                  cnt_reg [3];
	logic                           half_reg;
	logic [1:0]                     disp_hi_reg;
	logic [DW-1:0]                  hold_reg;
	logic [13:0]                    xfer_done_reg;
	logic                           sync_readout_strobe_reg;

	logic cpu_en;
	logic dsp_en;
	logic copy_req;
	logic dual;
	logic [6:0] x_step;
	logic [AW-1:0] xfer_addr;
	logic [AW-1:0] disp_addr;
	logic [AW-1:0] xdef_addr;
	logic [AW-1:0] copy_dst_addr;

	assign cpu_en   = ctl_sync_reg[sdm_pkg::CB_CPU_EN];
	assign dsp_en   = ctl_sync_reg[sdm_pkg::CB_DSP_EN];
	assign copy_req = ctl_sync_reg[sdm_pkg::CB_COPY];
	assign dual     = ctl_sync_reg[sdm_pkg::CB_DUAL];
	// power-of-two step 1..64 from codes 0..6, zero from code 7, for horizontal expansion
	assign x_step = 7'h01 << ctl_sync_reg[sdm_pkg::CB_STEP0 +: 3];

	// first latch follows the host strobe, second resamples on a
	// readout pulse so a half-written word is never used
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			ctl_first_reg <= '0;
			sync_readout_strobe_reg      <= 1'b0;
		end else begin
			sync_readout_strobe_reg <= control_latch_strobe;
			if (control_latch_strobe) begin
				ctl_first_reg <= host_data_bus[6:0];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			ctl_sync_reg <= '0;
		end else if (sync_readout_strobe_reg) begin
			ctl_sync_reg <= ctl_first_reg;
		end
	end

	// strobe comes from the acquisition clock domain
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			strobe_meta_reg <= 1'b0;
			strobe_sync_reg <= 1'b0;
		end else begin
			strobe_meta_reg <= sample_ready_strobe;
			strobe_sync_reg <= strobe_meta_reg;
		end
	end

	// address formation per counter
	always_comb begin
		// dual mode: sample pairs A then B share one counter value
		if (dual) begin
			xfer_addr = {2'b00, cnt_reg[0], half_reg};
		end else begin
			xfer_addr = {2'b00, half_reg, cnt_reg[0]};
		end
		disp_addr = {disp_hi_reg, cnt_reg[1], 1'b0};
		xdef_addr = {host_static_bits, 1'b0, cnt_reg[2]};
		copy_dst_addr = sdm_pkg::REG_BASE | {3'b000, cnt_reg[2]};
	end

	// main sequencer; host access and copy beat the sample strobe, which
	// is harmless because the acquisition side holds it until taken
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			state_reg     <= sdm_pkg::SDM_IDLE;
			half_reg      <= 1'b0;
			disp_hi_reg   <= 2'b00;
			hold_reg      <= '0;
			xfer_done_reg <= '0;
			for (int i = 0; i < 3; i++) begin
				cnt_reg[i] <= '0;
			end
		end else begin
			unique case (state_reg)
				sdm_pkg::SDM_IDLE: begin
					if (cpu_en) begin
						state_reg <= sdm_pkg::SDM_IDLE;
					end else if (copy_req) begin
						cnt_reg[1] <= '0;
						cnt_reg[2] <= '0;
						state_reg  <= sdm_pkg::SDM_CRD;
					end else if (strobe_sync_reg) begin
						state_reg <= sdm_pkg::SDM_XFER;
					end else if (dsp_en) begin
						state_reg <= sdm_pkg::SDM_FETCH;
					end
					// preset only while idle so a fetch never sees half a load
					if (disp_preset_load) begin
						cnt_reg[1]  <= host_addr[CW:1];
						disp_hi_reg <= host_addr[AW-1:AW-2];
					end
				end
				sdm_pkg::SDM_XFER: begin
					// sample written this cycle; then advance address.
					// the halving stage is the low bit in dual, the top in single
					if (dual) begin
						{cnt_reg[0], half_reg} <= {cnt_reg[0], half_reg} + 13'h0001;
					end else begin
						{half_reg, cnt_reg[0]} <= {half_reg, cnt_reg[0]} + 13'h0001;
					end
					xfer_done_reg <= xfer_done_reg + 14'h0001;
					state_reg <= sdm_pkg::SDM_XWAIT;
				end
				sdm_pkg::SDM_XWAIT: begin
					if (!strobe_sync_reg) begin
						state_reg <= sdm_pkg::SDM_IDLE;
					end
					// wrap after a full screen so the next fill starts at zero
					if (xfer_done_reg == 14'(XFER_LEN)) begin
						cnt_reg[0]    <= '0;
						half_reg      <= 1'b0;
						xfer_done_reg <= '0;
					end
				end
				sdm_pkg::SDM_FETCH: begin
					hold_reg  <= display_data_out;
					state_reg <= sdm_pkg::SDM_SHOW;
				end
				sdm_pkg::SDM_SHOW: begin
					cnt_reg[1] <= cnt_reg[1] + 12'h001;
					cnt_reg[2] <= cnt_reg[2] + {5'b00000, x_step};
					state_reg  <= sdm_pkg::SDM_IDLE;
				end
				sdm_pkg::SDM_CRD: begin
					hold_reg  <= display_data_out;
					state_reg <= sdm_pkg::SDM_CWR;
				end
				sdm_pkg::SDM_CWR: begin
					cnt_reg[1] <= cnt_reg[1] + 12'h001;
					cnt_reg[2] <= cnt_reg[2] + 12'h001;
					// stop at the end of the 4K register area even if copy stays set
					if (!copy_req || &cnt_reg[2]) begin
						state_reg <= sdm_pkg::SDM_IDLE;
					end else begin
						state_reg <= sdm_pkg::SDM_CRD;
					end
				end
				default: state_reg <= sdm_pkg::SDM_IDLE;
			endcase
			// terminal count restarts the fill from zero in any state,
			// since it may arrive while a copy holds the sequencer
			if (transfer_terminal_count) begin
				cnt_reg[0]    <= '0;
				half_reg      <= 1'b0;
				xfer_done_reg <= '0;
			end
		end
	end

	// memory port and strobes; every output registered
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			display_address      <= '0;
			mem_wdata            <= '0;
			ram_select_n         <= 1'b1;
			ram_write_enable_n   <= 1'b1;
			cpu_ram_enable_n     <= 1'b1;
			latch_to_ram_n       <= 1'b1;
			latch_read_enable_n  <= 1'b1;
			transfer_count_clock <= 1'b0;
			counter_select       <= sdm_pkg::SEL_XFER;
			high_bit_set_n       <= 1'b1;
			high_bit_reset_n     <= 1'b1;
			high_bit_clock       <= 1'b0;
			copy_latch_clock     <= 1'b0;
			copy_latch_enable_n  <= 1'b1;
			host_rdata           <= '0;
			acq_halt             <= 1'b0;
		end else begin
			ram_select_n         <= 1'b1;
			ram_write_enable_n   <= 1'b1;
			latch_to_ram_n       <= 1'b1;
			transfer_count_clock <= 1'b0;
			high_bit_clock       <= 1'b0;
			copy_latch_clock     <= 1'b0;
			// set and reset force the external high address bit to the preset
			high_bit_set_n       <= ~disp_hi_reg[0];
			high_bit_reset_n     <= disp_hi_reg[0];
			cpu_ram_enable_n     <= ~cpu_en;
			acq_halt             <= copy_req;
			copy_latch_enable_n  <= ~(state_reg == sdm_pkg::SDM_CWR);
			latch_read_enable_n  <= ~(state_reg == sdm_pkg::SDM_XFER);
			// read data settle one cycle after the host address is set up
			if (!cpu_ram_enable_n && !ram_select_n && ram_write_enable_n) begin
				host_rdata <= display_data_out;
			end
			// a sample already taken when the host path opens is still
			// written, or the acquisition side would wait for it forever
			if (cpu_en && state_reg != sdm_pkg::SDM_XFER) begin
				// host path reaches any location; reset pattern comes from host
				display_address    <= host_addr;
				mem_wdata          <= host_data_bus;
				ram_select_n       <= ~(host_wr | host_rd);
				ram_write_enable_n <= ~host_wr;
			end else begin
				unique case (state_reg)
					sdm_pkg::SDM_XFER: begin
						counter_select       <= sdm_pkg::SEL_XFER;
						display_address      <= xfer_addr;
						mem_wdata            <= sample_data;
						ram_select_n         <= 1'b0;
						ram_write_enable_n   <= 1'b0;
						latch_to_ram_n       <= 1'b0;
						transfer_count_clock <= 1'b1;
					end
					sdm_pkg::SDM_FETCH: begin
						counter_select  <= sdm_pkg::SEL_DISP;
						display_address <= disp_addr;
						ram_select_n    <= 1'b0;
						high_bit_clock  <= 1'b1;
					end
					sdm_pkg::SDM_SHOW: begin
						counter_select  <= sdm_pkg::SEL_XDEF;
						display_address <= xdef_addr;
					end
					sdm_pkg::SDM_CRD: begin
						counter_select   <= sdm_pkg::SEL_DISP;
						display_address  <= disp_addr;
						ram_select_n     <= 1'b0;
						copy_latch_clock <= 1'b1;
					end
					sdm_pkg::SDM_CWR: begin
						counter_select     <= sdm_pkg::SEL_XDEF;
						display_address    <= copy_dst_addr;
						mem_wdata          <= hold_reg;
						ram_select_n       <= 1'b0;
						ram_write_enable_n <= 1'b0;
					end
					default: begin
						display_address <= display_address;
					end
				endcase
			end
		end
	end

	// deflection and intensity selection; the X code drops the two low
	// counter bits, so at step 1 four samples share each horizontal position
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			y_dac_code       <= '0;
			x_dac_code       <= '0;
			spot_intensity_n <= 1'b1;
			xy_source_switch <= 1'b0;
		end else if (memory_mode_n) begin
			// selector idle outside memory mode: beam held off
			spot_intensity_n <= 1'b1;
			xy_source_switch <= 1'b0;
		end else if (trace_mode_signal) begin
			y_dac_code       <= hold_reg;
			x_dac_code       <= cnt_reg[2][11:2];
			// copy has no signal display on screen
			spot_intensity_n <= signal_intensity_n | copy_req;
			xy_source_switch <= signal_xy_clock;
		end else begin
			y_dac_code       <= text_y;
			x_dac_code       <= text_x;
			spot_intensity_n <= ~text_intensity;
			xy_source_switch <= text_clock;
		end
	end

	// lock mode is observed by the host only; no local effect
	logic unused_lock;
	assign unused_lock = lock_in;
endmodule : sdm_display_ctrl
`default_nettype wire

// ===== sdm_display_ctrl_chk.sv
// port assertions for the display memory control block
`timescale 1ns/1ps
`default_nettype none
module sdm_display_ctrl_chk #(
	parameter int XFER_LEN = 8192
) (
	// clock, reset, handshake and memory strobes
	input wire logic        ref_clk,
	input wire logic        rstn,
	input wire logic        sample_ready_strobe,
	input wire logic        latch_read_enable_n,
	input wire logic        acq_halt,
	input wire logic        ram_select_n,
	input wire logic        ram_write_enable_n,
	input wire logic        cpu_ram_enable_n,
	input wire logic [1:0]  counter_select,
	// host port
	input wire logic        host_wr,
	input wire logic        host_rd,
	input wire logic [14:0] host_addr,
	input wire logic [14:0] display_address,
	// output selector
	input wire logic        memory_mode_n,
	input wire logic        trace_mode_signal,
	input wire logic        signal_intensity_n,
	input wire logic        text_clock,
	input wire logic        signal_xy_clock,
	input wire logic [7:0]  text_y,
	input wire logic [9:0]  text_x,
	input wire logic [7:0]  y_dac_code,
	input wire logic [9:0]  x_dac_code,
	input wire logic        spot_intensity_n,
	input wire logic        xy_source_switch
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	a_text_y: assert property (
		!memory_mode_n && !trace_mode_signal |=> y_dac_code == $past(text_y))
		else $error("y code does not follow text");
	a_text_x: assert property (
		!memory_mode_n && !trace_mode_signal |=> x_dac_code == $past(text_x))
		else $error("x code does not follow text");
	a_sel_hold: assert property (
		memory_mode_n |=> $stable(y_dac_code) && $stable(x_dac_code))
		else $error("codes moved outside memory mode");
	a_spot_sig: assert property (
		!memory_mode_n && trace_mode_signal
		|=> spot_intensity_n == ($past(signal_intensity_n) | acq_halt))
		else $error("spot does not follow signal intensity");
	a_xy_switch: assert property (
		!memory_mode_n |=> xy_source_switch == ($past(trace_mode_signal) ?
		$past(signal_xy_clock) : $past(text_clock)))
		else $error("xy switch carries wrong clock");
	a_take_once: assert property (
		$fell(latch_read_enable_n) |=> latch_read_enable_n)
		else $error("latch enable low over one cycle");
	a_take_write: assert property (
		!latch_read_enable_n |-> !ram_write_enable_n && !ram_select_n)
		else $error("sample taken without ram write");
	a_sync_wait: assert property (
		!latch_read_enable_n |-> $past(sample_ready_strobe, 2))
		else $error("sample taken before strobe synchronised");
	a_one_sel: assert property (counter_select != 2'b11)
		else $error("unused counter select code");
	a_take_sel: assert property (
		!latch_read_enable_n |-> counter_select == 2'b00)
		else $error("sample written through wrong counter");
	a_host_addr: assert property (
		!cpu_ram_enable_n && latch_read_enable_n
		|-> display_address == $past(host_addr)
		&& (ram_select_n != ($past(host_wr) || $past(host_rd))))
		else $error("host ram access does not match request");
endmodule : sdm_display_ctrl_chk
bind sdm_display_ctrl sdm_display_ctrl_chk #(.XFER_LEN(XFER_LEN)) u_chk (.*);
`default_nettype wire

// ===== sdm_acq_model.sv
// acquisition side model: hands samples over by strobe handshake
`timescale 1ns/1ps
`default_nettype none
module sdm_acq_model (
	// clock, reset and handshake
	input  wire logic       acq_clk,
	input  wire logic       rstn,
	input  wire logic       latch_read_enable_n,
	input  wire logic       acq_halt,
	output logic            sample_ready_strobe,
	output logic [7:0]      sample_data
);
	int i = 0;
	bit taken = 0;
	// the take pulse is shorter than our period, so catch its edge
	always @(negedge latch_read_enable_n) taken = 1;
	initial begin
		sample_ready_strobe = 0;
		sample_data = 8'h00;
		wait (rstn);
		forever begin
			repeat ($urandom_range(1, 5)) @(posedge acq_clk);
			if (!acq_halt) begin
				taken = 0;
				sample_data <= 8'(i * 37 + 5);
				sample_ready_strobe <= 1;
				while (!taken || !latch_read_enable_n) @(posedge acq_clk);
				sample_ready_strobe <= 0;
				i++;
				// released latch no longer shows the old sample
				@(posedge acq_clk) sample_data <= ~sample_data;
			end
		end
	end
endmodule : sdm_acq_model
`default_nettype wire

// ===== sdm_display_ctrl_tb.sv
// self-checking bench for the display memory control block
`timescale 1ns/1ps
`default_nettype none
module sdm_display_ctrl_tb;
	localparam int XL = 16;
	logic ref_clk = 0, rstn = 0, acq_clk = 0, control_latch_strobe = 0;
	logic host_wr = 0, host_rd = 0, disp_preset_load = 0, lock_in = 0;
	logic transfer_terminal_count = 0, memory_mode_n = 0, trace_mode_signal = 0;
	logic signal_intensity_n = 1, text_intensity = 0, text_clock = 0;
	logic signal_xy_clock = 0, sample_ready_strobe, latch_read_enable_n;
	logic acq_halt, ram_select_n, ram_write_enable_n, cpu_ram_enable_n;
	logic latch_to_ram_n, transfer_count_clock, high_bit_set_n;
	logic high_bit_reset_n, high_bit_clock, copy_latch_clock;
	logic copy_latch_enable_n, spot_intensity_n, xy_source_switch;
	logic [1:0]  counter_select, host_static_bits = 0;
	logic [7:0]  sample_data, host_data_bus = 0, host_rdata, text_y = 0;
	logic [7:0]  mem_wdata, display_data_out, y_dac_code, mem [0:32767];
	logic [9:0]  text_x = 0, x_dac_code;
	logic [14:0] host_addr = 0, display_address, a;
	logic [7:0]  wd;
	int err_count = 0, n_tests = 0, k = 0, base = 0;
	bit rnd = 0;
	always #12.5 ref_clk = ~ref_clk;
	// unrelated 20 MHz acquisition clock
	initial #7 forever #25 acq_clk = ~acq_clk;
	sdm_display_ctrl #(.XFER_LEN(XL)) dut (.*);
	sdm_acq_model acq (.*);
	assign display_data_out = mem[display_address];
	always @(posedge ref_clk)
		if (!ram_select_n && !ram_write_enable_n) mem[display_address] <= mem_wdata;
	always @(posedge ref_clk) if (rnd) begin
		text_y <= 8'($urandom);
		text_x <= 10'($urandom);
		{trace_mode_signal, signal_intensity_n, text_intensity} <= 3'($urandom);
		{text_clock, signal_xy_clock, host_static_bits} <= 4'($urandom);
		memory_mode_n <= ($urandom % 8) == 0;
	end
	function automatic logic [7:0] smp(input int i);
		return 8'(i * 37 + 5);
	endfunction : smp
	task automatic check(input logic [14:0] got, input logic [14:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	always @(posedge ref_clk) if (rstn && !latch_read_enable_n) begin
		check(display_address, 15'((k - base) % XL));
		check(15'(mem_wdata), 15'(smp(k)));
		k++;
	end
	task automatic ctl(input logic [7:0] d);
		host_data_bus <= d;
		control_latch_strobe <= 1;
		@(posedge ref_clk) control_latch_strobe <= 0;
		repeat (4) @(posedge ref_clk);
	endtask : ctl
	task automatic hw(input logic [14:0] ad, input logic [7:0] d);
		host_addr <= ad;
		host_data_bus <= d;
		host_wr <= 1;
		@(posedge ref_clk) host_wr <= 0;
		@(posedge ref_clk);
	endtask : hw
	task automatic hr(input logic [14:0] ad, input logic [7:0] d);
		host_addr <= ad;
		host_rd <= 1;
		@(posedge ref_clk) host_rd <= 0;
		repeat (2) @(posedge ref_clk);
		#1 check(15'(host_rdata), 15'(d));
	endtask : hr
	task automatic wait_n(input int n);
		int t;
		t = 0;
		n = n + k;
		while (k < n && t < 3000) begin
			@(posedge ref_clk);
			t++;
		end
		check(15'(k >= n), 15'h0001);
	endtask : wait_n
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict
	initial begin
		#(20000 * 25);
		err_count++;
		print_verdict;
	end
	initial begin
		$urandom(13357);
		repeat (10) @(posedge ref_clk);
		rstn <= 1;
		rnd <= 1;
		@(posedge ref_clk);
		ctl(8'h02);
		wait_n(20);
		ctl(8'h0E);
		check(15'(acq_halt), 15'h0001);
		repeat (20) @(posedge ref_clk);
		transfer_terminal_count <= 1;
		@(posedge ref_clk) transfer_terminal_count <= 0;
		base = k;
		// dual channel with a random horizontal step
		ctl(8'h0A | {1'b0, 3'($urandom_range(0, 6)), 4'h0});
		check(15'(acq_halt), 15'h0000);
		wait_n(20);
		ctl(8'h01);
		for (int j = 0; j < 8; j++) begin
			a = 15'($urandom);
			wd = j == 0 ? 8'h80 : 8'($urandom);
			hw(a, wd);
			hr(a, wd);
		end
		print_verdict;
	end
endmodule : sdm_display_ctrl_tb
`default_nettype wire
